//--- hw/dsec_top.sv
// Purpose: debug status reporting and breakpoint handling for a 32-bit core
// Assumes: decode stage presents one instruction per cycle with valid
// Notes: registers are word indices; register port reads answer one cycle later
`timescale 1ns/1ns
`default_nettype none
module dsec_top (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic active_low_reset,
  input wire logic fetch_permit_in,
  input wire logic debug_request_in,
  input wire logic [31:0] halt_entry_address_in,
  input wire logic [31:0] debug_exception_address_in,
  input wire dsec_pkg::dsec_instr_t instr_i,
  input wire logic [dsec_pkg::dsec_aw-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_err_o,
  output dsec_pkg::dsec_status_t status_o,
  output logic reset_seen_flag_out,
  output logic running_flag_out,
  output logic halted_flag_out,
  output dsec_pkg::dsec_redirect_t redirect_o,
  output logic instr_kill_o,
  output logic fetch_enable_o,
  output logic debug_mode_o,
  output logic irq_o
);
  // ==========================================
  // state
  dsec_pkg::dsec_state_t state;
  dsec_pkg::dsec_state_t next_state;
  logic in_reset;
  logic permit_seen;
  logic [2:0] release_cnt;
  logic release_done;
  logic req_pending;
  logic [31:0] dcsr;
  logic [31:0] dpc;
  logic [31:0] mepc;
  logic [31:0] mcause;
  logic [31:0] tvec;
  logic ebreakm;
  logic do_trap;
  logic do_dbg_enter_bkpt;
  logic do_dbg_restart;
  logic do_dbg_exc;
  logic do_dbg_req;
  logic csr_we_ok;
  logic [dsec_pkg::dsec_n_events-1:0] events;
  logic [dsec_pkg::dsec_n_events-1:0] ev_status;
  logic [dsec_pkg::dsec_n_events-1:0] ev_mask;
  logic ev_clear;

  assign in_reset = srst_i | ~active_low_reset;
  assign ebreakm = dcsr[dsec_pkg::dsec_ebreakm_bit];
  assign release_done = permit_seen && (release_cnt == dsec_pkg::dsec_release_cycles);

  // ==========================================
  // release from unavailable
  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      permit_seen <= 1'b0;
    end else if (fetch_permit_in) begin
      permit_seen <= 1'b1; // [RULE3] [RULE15]
    end
  end

  always_ff @(posedge clock_i) begin
    if (in_reset || !permit_seen) begin
      release_cnt <= '0; // [RULE5]
    end else if (!release_done) begin
      release_cnt <= release_cnt + 3'h1;
    end
  end

  // request seen during the unavailable window is held for the release
  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      req_pending <= 1'b0;
    end else if (state != dsec_pkg::dsec_st_unavail) begin
      req_pending <= 1'b0;
    end else if (debug_request_in) begin
      req_pending <= 1'b1; // [RULE6]
    end
  end

  // ==========================================
  // breakpoint and request decisions
  always_comb begin
    do_trap = 1'b0;
    do_dbg_enter_bkpt = 1'b0;
    do_dbg_restart = 1'b0;
    do_dbg_exc = 1'b0;
    do_dbg_req = 1'b0;
    if (state == dsec_pkg::dsec_st_running) begin
      if (debug_request_in) begin
        do_dbg_req = 1'b1; // [RULE8] [RULE14]
      end else if (instr_i.valid && instr_i.ebreak) begin
        do_trap = !ebreakm; // [RULE9]
        do_dbg_enter_bkpt = ebreakm; // [RULE11]
      end
    end else if (state == dsec_pkg::dsec_st_halted && instr_i.valid) begin
      if (instr_i.ebreak) begin
        do_dbg_restart = 1'b1; // [RULE13]
      end else if (instr_i.exception || instr_i.mret) begin
        do_dbg_exc = 1'b1; // [RULE17]
      end
    end
  end

  // the instruction in decode when the request arrives is killed
  assign instr_kill_o = do_dbg_req; // [RULE14]

  always_comb begin
    next_state = state;
    unique case (state)
      dsec_pkg::dsec_st_unavail: begin
        if (release_done) begin
          next_state = (req_pending || debug_request_in) ? dsec_pkg::dsec_st_halted
                                                         : dsec_pkg::dsec_st_running; // [RULE6] [RULE7]
        end
      end
      dsec_pkg::dsec_st_running: begin
        if (do_dbg_req || do_dbg_enter_bkpt) begin
          next_state = dsec_pkg::dsec_st_halted; // [RULE8] [RULE11]
        end
      end
      dsec_pkg::dsec_st_halted: begin
        next_state = dsec_pkg::dsec_st_halted;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      state <= dsec_pkg::dsec_st_unavail; // [RULE3]
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // status flags, registered
  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      reset_seen_flag_out <= 1'b1; // [RULE15]
      running_flag_out <= 1'b0;
      halted_flag_out <= 1'b0;
    end else begin
      reset_seen_flag_out <= (next_state == dsec_pkg::dsec_st_unavail); // [RULE4] [RULE18]
      running_flag_out <= (next_state == dsec_pkg::dsec_st_running); // [RULE1] [RULE2]
      halted_flag_out <= (next_state == dsec_pkg::dsec_st_halted); // [RULE1]
    end
  end

  always_comb begin
    status_o.havereset = reset_seen_flag_out;
    status_o.running = running_flag_out;
    status_o.halted = halted_flag_out;
  end
  assign debug_mode_o = halted_flag_out;
  assign fetch_enable_o = !reset_seen_flag_out;

  // ==========================================
  // fetch redirect
  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      redirect_o <= '0;
    end else begin
      redirect_o.valid <= do_trap | do_dbg_req | do_dbg_enter_bkpt | do_dbg_restart | do_dbg_exc
                          | (state == dsec_pkg::dsec_st_unavail && next_state == dsec_pkg::dsec_st_halted);
      if (do_trap) begin
        redirect_o.addr <= {tvec[31:2], dsec_pkg::dsec_align_mask}; // [RULE9]
      end else if (do_dbg_exc) begin
        redirect_o.addr <= {debug_exception_address_in[31:2], dsec_pkg::dsec_align_mask}; // [RULE16] [RULE17]
      end else begin
        redirect_o.addr <= {halt_entry_address_in[31:2], dsec_pkg::dsec_align_mask}; // [RULE11] [RULE13] [RULE16]
      end
    end
  end

  // ==========================================
  // control and status registers
  assign csr_we_ok = reg_we_i && halted_flag_out; // [RULE12]

  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      dcsr <= dsec_pkg::dsec_dcsr_rst; // [RULE12]
      dpc <= '0;
    end else if (do_dbg_req || do_dbg_enter_bkpt) begin
      dpc <= instr_i.pc; // [RULE11] [RULE14]
      dcsr[dsec_pkg::dsec_cause_lsb +: 3] <= do_dbg_req ? dsec_pkg::dsec_cause_haltreq
                                                        : dsec_pkg::dsec_cause_ebreak;
    end else if (csr_we_ok && reg_addr_i == dsec_pkg::dsec_reg_dcsr) begin
      dcsr <= reg_wdata_i; // [RULE12]
    end else if (csr_we_ok && reg_addr_i == dsec_pkg::dsec_reg_dpc) begin
      dpc <= reg_wdata_i;
    end
  end

  // machine trap registers; no trap value register exists [RULE10]
  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      mepc <= '0;
      mcause <= '0;
      tvec <= dsec_pkg::dsec_tvec_rst;
    end else if (do_trap) begin
      mepc <= instr_i.pc; // [RULE9]
      mcause <= dsec_pkg::dsec_mcause_bkpt;
    end else if (reg_we_i && !do_dbg_restart && !do_dbg_exc) begin
      if (reg_addr_i == dsec_pkg::dsec_reg_mepc) mepc <= reg_wdata_i;
      if (reg_addr_i == dsec_pkg::dsec_reg_mcause) mcause <= reg_wdata_i;
      if (reg_addr_i == dsec_pkg::dsec_reg_tvec) tvec <= reg_wdata_i;
    end
  end

  // ==========================================
  // events and interrupt
  always_comb begin
    events = '0;
    events[dsec_pkg::dsec_ev_trap] = do_trap;
    events[dsec_pkg::dsec_ev_dbg_enter] = do_dbg_req | do_dbg_enter_bkpt;
    events[dsec_pkg::dsec_ev_dbg_restart] = do_dbg_restart;
    events[dsec_pkg::dsec_ev_dbg_exc] = do_dbg_exc;
  end
  assign ev_clear = reg_re_i && reg_addr_i == dsec_pkg::dsec_reg_irq_stat;

  dsec_event_regs #(
    .N(dsec_pkg::dsec_n_events)
  ) u_events (
    .clock_i(clock_i),
    .srst_i(in_reset),
    .event_i(events),
    .clear_i(ev_clear),
    .mask_we_i(reg_we_i && reg_addr_i == dsec_pkg::dsec_reg_irq_mask),
    .mask_wdata_i(reg_wdata_i[dsec_pkg::dsec_n_events-1:0]),
    .status_o(ev_status),
    .mask_o(ev_mask),
    .irq_o(irq_o)
  );

  // ==========================================
  // read port, data one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (in_reset) begin
      reg_rdata_o <= '0;
      reg_err_o <= 1'b0;
    end else begin
      reg_rdata_o <= '0;
      reg_err_o <= 1'b0;
      if (reg_re_i) begin
        unique case (reg_addr_i)
          dsec_pkg::dsec_reg_dcsr: begin
            if (halted_flag_out) reg_rdata_o <= dcsr;
            else reg_err_o <= 1'b1; // [RULE12]
          end
          dsec_pkg::dsec_reg_dpc: begin
            if (halted_flag_out) reg_rdata_o <= dpc;
            else reg_err_o <= 1'b1;
          end
          dsec_pkg::dsec_reg_mepc: reg_rdata_o <= mepc;
          dsec_pkg::dsec_reg_mcause: reg_rdata_o <= mcause;
          dsec_pkg::dsec_reg_tvec: reg_rdata_o <= tvec;
          dsec_pkg::dsec_reg_status: reg_rdata_o <= {29'h0, halted_flag_out, running_flag_out, reset_seen_flag_out};
          dsec_pkg::dsec_reg_irq_stat: reg_rdata_o <= {28'h0, ev_status};
          dsec_pkg::dsec_reg_irq_mask: reg_rdata_o <= {28'h0, ev_mask};
          default: reg_err_o <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- include/dsec_pkg.sv
// Purpose: shared constants and types for the debug state and breakpoint control block
// Assumes: single core clock, synchronous active-high reset srst_i
// Notes: plain register port; registers are word indices at byte offsets of four
// Notes on behaviour
// RULE1: running flag while executing normally, halted flag while in debug mode.
// RULE2: neither running nor halted means the core is unavailable.
// RULE3: unavailable from reset until some cycles after release and fetch permit.
// RULE4: exactly one of reset-seen, running and halted is high every cycle.
// RULE5: unavailable may last forever while reset holds or permit stays low.
// RULE6: request before or with fetch permit goes straight unavailable to halted.
// RULE7: request after fetch permit may briefly show running before halted.
// RULE8: request while running reaches halted within a few cycles.
// RULE9: breakpoint outside debug with enable 0 traps to vector, updates return pc, cause.
// RULE10: no trap value register; instruction encoding is not saved.
// RULE11: breakpoint outside debug with enable 1 enters debug at halt address.
// RULE12: break-to-debug enable resets to 0, writable only in debug mode.
// RULE13: breakpoint inside debug restarts at halt address, no register changes.
// RULE14: request held one clock; instruction decoded at first request cycle not executed.
// RULE15: reset-seen high during reset, clears after release and permit sampled.
// RULE16: debug module gives word-aligned halt and exception addresses.
// RULE17: in debug, exception or mret goes to exception address, status unchanged.
// RULE18: status outputs come from registered state, never glitching.
package dsec_pkg;
  localparam int unsigned dsec_aw = 4;
  localparam logic [dsec_aw-1:0] dsec_reg_dcsr = 4'h0;
  localparam logic [dsec_aw-1:0] dsec_reg_dpc = 4'h1;
  localparam logic [dsec_aw-1:0] dsec_reg_mepc = 4'h2;
  localparam logic [dsec_aw-1:0] dsec_reg_mcause = 4'h3;
  localparam logic [dsec_aw-1:0] dsec_reg_tvec = 4'h4;
  localparam logic [dsec_aw-1:0] dsec_reg_status = 4'h5;
  localparam logic [dsec_aw-1:0] dsec_reg_irq_stat = 4'h6;
  localparam logic [dsec_aw-1:0] dsec_reg_irq_mask = 4'h7;
  localparam int unsigned dsec_ebreakm_bit = 15;
  localparam int unsigned dsec_cause_lsb = 6;
  localparam logic [2:0] dsec_cause_ebreak = 3'h1;
  localparam logic [2:0] dsec_cause_haltreq = 3'h3;
  localparam logic [31:0] dsec_mcause_bkpt = 32'h0000_0003;
  localparam logic [31:0] dsec_tvec_rst = 32'h0000_0000;
  localparam logic [31:0] dsec_dcsr_rst = 32'h4000_0003;
  localparam logic [1:0] dsec_align_mask = 2'h0;
  localparam logic [2:0] dsec_release_cycles = 3'h2;
  localparam int unsigned dsec_n_events = 4;
  localparam int unsigned dsec_ev_trap = 0;
  localparam int unsigned dsec_ev_dbg_enter = 1;
  localparam int unsigned dsec_ev_dbg_restart = 2;
  localparam int unsigned dsec_ev_dbg_exc = 3;

  typedef enum logic [1:0] {
    dsec_st_unavail,
    dsec_st_running,
    dsec_st_halted
  } dsec_state_t;

  typedef struct packed {
    logic valid;
    logic ebreak;
    logic exception;
    logic mret;
    logic [31:0] pc;
  } dsec_instr_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } dsec_redirect_t;

  typedef struct packed {
    logic havereset;
    logic running;
    logic halted;
  } dsec_status_t;
endpackage

//--- hw/dsec_event_regs.sv
// Purpose: sticky event status with mask and one level interrupt
// Assumes: read of status clears it; set wins over clear
// Notes: leaf of dsec_top
`timescale 1ns/1ns
`default_nettype none
module dsec_event_regs #(
  parameter int unsigned N = 4
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [N-1:0] event_i,
  input wire logic clear_i,
  input wire logic mask_we_i,
  input wire logic [N-1:0] mask_wdata_i,
  output logic [N-1:0] status_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);
  // ==========================================
  // sticky bits
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status_o <= '0;
    end else if (clear_i) begin
      status_o <= event_i;
    end else begin
      status_o <= status_o | event_i;
    end
  end

  // ==========================================
  // mask
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_o <= '0;
    end else if (mask_we_i) begin
      mask_o <= mask_wdata_i;
    end
  end

  assign irq_o = |(status_o & mask_o);
endmodule
`default_nettype wire

//--- sim/dsec_top_asserts.sv
// Purpose: port checker for dsec_top
// Assumes: one clock domain, srst_i synchronous reset
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module dsec_top_asserts (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic active_low_reset,
  input wire logic debug_request_in,
  input wire logic [31:0] halt_entry_address_in,
  input wire logic [31:0] debug_exception_address_in,
  input wire dsec_pkg::dsec_instr_t instr_i,
  input wire logic reset_seen_flag_out,
  input wire logic running_flag_out,
  input wire logic halted_flag_out,
  input wire dsec_pkg::dsec_redirect_t redirect_o,
  input wire logic instr_kill_o,
  input wire logic fetch_enable_o,
  input wire logic debug_mode_o
);
  // ==========================================
  // properties
  default clocking cb @(posedge clock_i); endclocking
  // core reset aborts every check in flight as well, except chk_reset_flag_up and chk_release_hold
  default disable iff (srst_i || !active_low_reset);
  sequence s_to_halt_addr;
    redirect_o.valid && halted_flag_out && redirect_o.addr == {$past(halt_entry_address_in[31:2]), 2'h0};
  endsequence
  sequence s_kill_then_halt;
    instr_kill_o ##1 s_to_halt_addr;
  endsequence
  chk_status_one_hot: assert property ($onehot({reset_seen_flag_out, running_flag_out, halted_flag_out}))
    else $error("status flags not one-hot");
  chk_reset_flag_up: assert property (disable iff (srst_i) !active_low_reset |=> reset_seen_flag_out)
    else $error("reset flag low after core reset");
  chk_release_hold: assert property (disable iff (srst_i) !active_low_reset ##1 active_low_reset |=> reset_seen_flag_out)
    else $error("availability shown right after core reset release");
  chk_mode_is_halt: assert property (debug_mode_o == halted_flag_out)
    else $error("debug mode differs from halted flag");
  chk_fetch_gate: assert property (fetch_enable_o == !reset_seen_flag_out)
    else $error("fetch enable differs from availability");
  chk_request_halts: assert property (running_flag_out && debug_request_in |-> s_kill_then_halt)
    else $error("request while running did not halt");
  chk_unavail_skip: assert property (reset_seen_flag_out && debug_request_in && active_low_reset
    |=> !running_flag_out [*8])
    else $error("running shown after early request");
  chk_break_dest: assert property (running_flag_out && instr_i.valid && instr_i.ebreak && !debug_request_in
    |=> redirect_o.valid && (halted_flag_out ? redirect_o.addr == {$past(halt_entry_address_in[31:2]), 2'h0}
    : running_flag_out))
    else $error("breakpoint outside debug not redirected");
  chk_dbg_restart: assert property (halted_flag_out && instr_i.valid && instr_i.ebreak |=> s_to_halt_addr)
    else $error("breakpoint in debug not sent to halt address");
  chk_dbg_exc: assert property (halted_flag_out && instr_i.valid && !instr_i.ebreak
    && (instr_i.exception || instr_i.mret) |=> redirect_o.valid && halted_flag_out
    && redirect_o.addr == {$past(debug_exception_address_in[31:2]), 2'h0})
    else $error("debug exception not sent to exception address");
endmodule
bind dsec_top dsec_top_asserts dsec_top_asserts_i (.clock_i, .srst_i, .active_low_reset, .debug_request_in,
  .halt_entry_address_in, .debug_exception_address_in, .instr_i, .reset_seen_flag_out, .running_flag_out,
  .halted_flag_out, .redirect_o, .instr_kill_o, .fetch_enable_o, .debug_mode_o);
`default_nettype wire

//--- sim/dsec_dm_model.sv
// Purpose: behavioural debug module facing dsec_top
// Assumes: go_i pulses one cycle, delay_i sets promptness
// Notes: request held until the core shows halted
`timescale 1ns/1ns
`default_nettype none
module dsec_dm_model (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [3:0] delay_i,
  input wire logic halted_i,
  output logic debug_request_in,
  output logic [31:0] halt_entry_address_in,
  output logic [31:0] debug_exception_address_in
);
  // ==========================================
  // request timing
  logic [4:0] wait_cnt;
  assign halt_entry_address_in = 32'h0000_0800;
  assign debug_exception_address_in = 32'h0000_0808;
  initial begin
    wait_cnt = 5'h00;
    debug_request_in = 1'b0;
  end
  always @(posedge clock_i) begin
    if (go_i) wait_cnt <= {1'b0, delay_i} + 5'h01;
    else if (wait_cnt != 5'h00) wait_cnt <= wait_cnt - 5'h01;
  end
  always @(posedge clock_i) begin
    if (wait_cnt == 5'h01) debug_request_in <= 1'b1;
    else if (halted_i) debug_request_in <= 1'b0;
  end
endmodule
`default_nettype wire

//--- sim/dsec_top_tb.sv
// Purpose: self-checking bench for dsec_top
// Assumes: 10 MHz clock, no resume from debug
// Notes: debug module modelled by dsec_dm_model
`timescale 1ns/1ns
`default_nettype none
module dsec_top_tb;
  logic clock_i, srst_i, active_low_reset, fetch_permit_in, go, reg_we_i, reg_re_i, reg_err_o, irq_o;
  logic reset_seen_flag_out, running_flag_out, halted_flag_out, instr_kill_o, fetch_enable_o, debug_mode_o;
  logic debug_request_in;
  logic [3:0] delay, reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, halt_entry_address_in, debug_exception_address_in;
  dsec_pkg::dsec_instr_t instr_i;
  dsec_pkg::dsec_status_t status_o;
  dsec_pkg::dsec_redirect_t redirect_o;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  dsec_top dsec_top_i (.clock_i, .srst_i, .active_low_reset, .fetch_permit_in, .debug_request_in,
    .halt_entry_address_in, .debug_exception_address_in, .instr_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .reg_err_o, .status_o, .reset_seen_flag_out, .running_flag_out, .halted_flag_out,
    .redirect_o, .instr_kill_o, .fetch_enable_o, .debug_mode_o, .irq_o);
  dsec_dm_model dsec_dm_model_i (.clock_i, .go_i(go), .delay_i(delay), .halted_i(halted_flag_out),
    .debug_request_in, .halt_entry_address_in, .debug_exception_address_in);
  // ==========================================
  // helpers
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize;
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic err);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
    chk({31'h0, reg_err_o}, {31'h0, err});
  endtask
  task automatic exec(input logic [2:0] kind, input logic [31:0] pc, input logic [31:0] dest);
    @(posedge clock_i);
    instr_i <= {1'b1, kind, pc};
    @(posedge clock_i);
    instr_i <= '0;
    #1 chk({31'h0, redirect_o.valid}, 32'h1);
    chk(redirect_o.addr, dest);
  endtask
  task automatic wait_flag(input logic want_halt, input logic no_run);
    int seen;
    seen = 0;
    for (int i = 0; i < 40 && (want_halt ? halted_flag_out : running_flag_out) !== 1'b1; i++) begin
      @(posedge clock_i);
      #1 if (running_flag_out === 1'b1) seen++;
    end
    chk({29'h0, reset_seen_flag_out, running_flag_out, halted_flag_out}, want_halt ? 32'h1 : 32'h2);
    chk({29'h0, status_o}, want_halt ? 32'h1 : 32'h2);
    chk({31'h0, debug_mode_o}, {31'h0, want_halt});
    chk({31'h0, fetch_enable_o}, 32'h1);
    if (no_run) chk(seen, 0);
  endtask
  // ==========================================
  // scenarios
  task automatic t_early_request;
    repeat (20) @(posedge clock_i);
    #1 chk({29'h0, reset_seen_flag_out, running_flag_out, halted_flag_out}, 32'h4);
    chk({31'h0, fetch_enable_o}, 32'h0);
    @(posedge clock_i);
    go <= 1'b1;
    delay <= 4'h0;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (3) @(posedge clock_i);
    fetch_permit_in <= 1'b1;
    wait_flag(1'b1, 1'b1);
  endtask
  task automatic t_debug_regs;
    rd(4'h5, 32'h4, 1'b0);
    rd(4'h0, dsec_pkg::dsec_dcsr_rst, 1'b0);
    wr(4'h0, 32'h4000_80c3);
    rd(4'h0, 32'h4000_80c3, 1'b0);
    exec(3'h4, 32'h40, halt_entry_address_in);
    rd(4'h0, 32'h4000_80c3, 1'b0);
    exec(3'h2, 32'h44, debug_exception_address_in);
    exec(3'h1, 32'h48, debug_exception_address_in);
  endtask
  task automatic t_core_reset;
    @(posedge clock_i);
    active_low_reset <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1 chk({31'h0, reset_seen_flag_out}, 32'h1);
    @(posedge clock_i);
    active_low_reset <= 1'b1;
    wait_flag(1'b0, 1'b0);
    rd(4'h0, 32'h0, 1'b1);
    wr(4'h0, 32'h4000_8003);
  endtask
  task automatic t_trap_irq;
    wr(4'h4, 32'h100);
    exec(3'h4, 32'h24, 32'h100);
    chk({31'h0, running_flag_out}, 32'h1);
    rd(4'h2, 32'h24, 1'b0);
    rd(4'h3, dsec_pkg::dsec_mcause_bkpt, 1'b0);
    rd(4'h9, 32'h0, 1'b1);
    chk({31'h0, irq_o}, 32'h0);
    wr(4'h7, 32'h1);
    #1 chk({31'h0, irq_o}, 32'h1);
    rd(4'h6, 32'h1, 1'b0);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_run_request;
    @(posedge clock_i);
    instr_i <= {1'b1, 3'h0, 32'h80};
    go <= 1'b1;
    delay <= 4'h3;
    @(posedge clock_i);
    go <= 1'b0;
    wait_flag(1'b1, 1'b0);
    @(posedge clock_i);
    instr_i <= '0;
    rd(4'h1, 32'h80, 1'b0);
    rd(4'h0, 32'h4000_00c3, 1'b0);
  endtask
  initial begin
    srst_i = 1'b1;
    active_low_reset = 1'b0;
    fetch_permit_in = 1'b0;
    go = 1'b0;
    delay = 4'h0;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    instr_i = '0;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    active_low_reset <= 1'b1;
    t_early_request();
    t_debug_regs();
    t_core_reset();
    t_trap_irq();
    t_run_request();
    summarize();
  end
endmodule
`default_nettype wire
